// file: verilog/i2sw_pkg.sv
package i2sw_pkg;

	// register addresses on the two-bit word address
	localparam logic [1:0] ADDR_DIVIDER_AND_THRESHOLD = 2'h0;
	localparam logic [1:0] ADDR_OPERATING_SETUP = 2'h1;
	localparam logic [1:0] ADDR_FIFO_STATE = 2'h2;
	localparam logic [1:0] ADDR_SAMPLE_PORT = 2'h3;

	// field positions in divider_and_threshold, and the bit count of operating_setup
	localparam int DIVIDER_LSB = 0;
	localparam int THRESHOLD_LSB = 8;
	localparam int SETUP_BITS = 15;

	// reset values
	localparam logic [31:0] DIVIDER_AND_THRESHOLD_RESET = 32'h0000_0000;
	localparam logic [31:0] OPERATING_SETUP_RESET = 32'h0000_0000;
	localparam logic [31:0] FIFO_STATE_RESET = 32'h0000_0032;

	// word width codes
	localparam logic [5:0] WIDTH_CODE_16 = 6'h10;
	localparam logic [5:0] WIDTH_CODE_20 = 6'h14;
	localparam logic [5:0] WIDTH_CODE_24 = 6'h18;
	localparam logic [5:0] WIDTH_CODE_32 = 6'h20;

	// fifo shape
	localparam int FIFO_DEPTH = 32;
	localparam int SAMPLE_BITS = 24;

	// bit slot shape per half frame of 256 oversample ticks
	localparam logic [4:0] SLOTS_16 = 5'h10;
	localparam logic [4:0] SLOTS_20 = 5'h15;
	localparam logic [4:0] SLOTS_24 = 5'h19;
	localparam logic [3:0] TICKS_16 = 4'h8;
	localparam logic [3:0] TICKS_20 = 4'h6;
	localparam logic [3:0] TICKS_24 = 4'h5;

	// decoded word width
	typedef enum logic [1:0] {
		I2SW_W16 = 2'b00,
		I2SW_W20 = 2'b01,
		I2SW_W24 = 2'b10,
		I2SW_W32 = 2'b11
	} i2sw_width_t;

	// operating_setup bits 14..0
	typedef struct packed {
		logic rx_irq_en;
		logic tx_irq_en;
		logic rx_en;
		logic tx_en;
		logic rx_side_right;
		logic rx_single_channel;
		logic tx_single_channel;
		logic [1:0] spare;
		logic [5:0] word_width;
	} i2sw_setup_t;

	// fifo_state bits 7..0
	typedef struct packed {
		logic rx_wmark;
		logic rx_full;
		logic rx_empty;
		logic rx_next_right;
		logic tx_wmark;
		logic tx_full;
		logic tx_empty;
		logic tx_next_right;
	} i2sw_status_t;

endpackage : i2sw_pkg

// file: verilog/i2sw_master.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] device always drives bit clock and word select
// [R2] setup bits 5..0 pick 16/20/24/32 width
// [R3] separate 32 by 24-bit transmit and receive fifos
// [R4] word select low left, toggles bit before msb
// [R5] one word select period carries left then right
// [R6] aux clock is 256 times word select rate
// [R7] control holds divider 7..0, watermark 15..8
// [R8] setup bits 14..8 hold enables and mono controls
// [R9] mono or stereo set per direction independently
// [R10] mono receive side bit picks captured channel
// [R11] status reports rx flags 7..4, tx 3..0
// [R12] next-channel flag 0 left, 1 right
// [R13] status resets to 32h, others zero
// [R14] address 0 control, 1 setup, 2 status, 3 data
// [R15] data write pushes tx, data read pops rx
// [R16] empty rx read leaves fifo unchanged
// [R17] tx watermark when level below threshold
// [R18] rx watermark when level above threshold
// [R19] interrupt high on any enabled watermark
// [R20] tx disable clears fifo, shifter, serial output
// [R21] rx disable clears fifo and shifter
// [R22] host strobes cycle, device acknowledges completion
// [R23] narrow widths take write bits 23..0
// [R24] 32-bit width uses bits 31..8, low byte zero
// [R25] narrow reads right-aligned and sign-extended
// [R26] bit clock 16, 21 or 25 per word select half
// [R27] full fifo drops new words silently
// [R28] empty tx fifo sends zero word

// plain first-in first-out store with synchronous clear
module i2sw_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic sys_clk,
	input wire logic clear,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata,
	output logic [AW:0] level
);
	logic [WIDTH-1:0] mem [DEPTH];  // storage
	logic [AW-1:0] wr_ptr;  // next free entry
	logic [AW-1:0] rd_ptr;  // oldest entry
	wire do_push = push && (level != (AW+1)'(DEPTH));  // [R27]
	wire do_pop = pop && (level != '0);  // [R16]

	assign rdata = mem[rd_ptr];

	// memory is not cleared; level alone decides validity
	always_ff @(posedge sys_clk)
	begin
		if (do_push)
			mem[wr_ptr] <= wdata;
	end

	// pointers and fill level
	always_ff @(posedge sys_clk)
	begin
		if (clear)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			level <= level + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : i2sw_fifo

// audio serial master with word-addressed register slave
module i2sw_master #(
	parameter int FIFO_DEPTH = i2sw_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	output logic int_o,
	output logic bit_clock,
	output logic word_select,
	output logic serial_out_line,
	input wire logic serial_in_line,
	output logic aux_oversample_clock
);
	localparam int SB = i2sw_pkg::SAMPLE_BITS;

	// register state
	logic [7:0] divider;  // prescaler
	logic [7:0] threshold;  // watermark
	i2sw_pkg::i2sw_setup_t setup;

	// bus take: one request per ack, so back-to-back gets a gap
	wire take = cyc_i && stb_i && !ack_o;  // [R22]
	wire wr_take = take && we_i;
	wire rd_take = take && !we_i;
	wire sel_div = (adr_i == i2sw_pkg::ADDR_DIVIDER_AND_THRESHOLD);  // [R14]
	wire sel_setup = (adr_i == i2sw_pkg::ADDR_OPERATING_SETUP);
	wire sel_state = (adr_i == i2sw_pkg::ADDR_FIFO_STATE);
	wire sel_port = (adr_i == i2sw_pkg::ADDR_SAMPLE_PORT);

	// section resets hold while disabled
	wire tx_clear = !rst_n || !setup.tx_en;  // [R20]
	wire rx_clear = !rst_n || !setup.rx_en;  // [R21]

	// width decode; unknown codes behave as 16-bit
	i2sw_pkg::i2sw_width_t wsel;
	assign wsel = (setup.word_width == i2sw_pkg::WIDTH_CODE_20) ? i2sw_pkg::I2SW_W20 :  // [R2]
		(setup.word_width == i2sw_pkg::WIDTH_CODE_24) ? i2sw_pkg::I2SW_W24 :
		(setup.word_width == i2sw_pkg::WIDTH_CODE_32) ? i2sw_pkg::I2SW_W32 :
		i2sw_pkg::I2SW_W16;
	wire w16 = (wsel == i2sw_pkg::I2SW_W16);
	wire w20 = (wsel == i2sw_pkg::I2SW_W20);
	wire w32 = (wsel == i2sw_pkg::I2SW_W32);

	// slots per half, ticks per slot, sample bits
	wire [4:0] slots = w16 ? i2sw_pkg::SLOTS_16 :  // [R26]
		w20 ? i2sw_pkg::SLOTS_20 : i2sw_pkg::SLOTS_24;
	wire [3:0] tpb = w16 ? i2sw_pkg::TICKS_16 :
		w20 ? i2sw_pkg::TICKS_20 : i2sw_pkg::TICKS_24;
	wire [4:0] nbits = w16 ? 5'h10 : w20 ? 5'h14 : 5'h18;

	// register writes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			divider <= i2sw_pkg::DIVIDER_AND_THRESHOLD_RESET[7:0];  // [R13]
			threshold <= i2sw_pkg::DIVIDER_AND_THRESHOLD_RESET[15:8];
			setup <= i2sw_pkg::OPERATING_SETUP_RESET[i2sw_pkg::SETUP_BITS-1:0];
		end
		else if (wr_take && sel_div)
		begin
			divider <= dat_i[i2sw_pkg::DIVIDER_LSB +: 8];  // [R7]
			threshold <= dat_i[i2sw_pkg::THRESHOLD_LSB +: 8];
		end
		else if (wr_take && sel_setup)
			setup <= dat_i[i2sw_pkg::SETUP_BITS-1:0];  // [R8] [R9]
	end

	// prescaler: one tick every divider+1 clocks, tick rate 512 fs
	logic [7:0] pre_cnt;
	wire tick = (pre_cnt == divider);  // [R7]
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || tick)
			pre_cnt <= '0;
		else
			pre_cnt <= pre_cnt + 1'b1;
	end

	// half-frame timing: 256 ticks per word select half
	logic [7:0] phase;  // tick within half frame
	logic [3:0] sub;  // tick within bit slot
	logic [4:0] slot;  // bit slot within half frame
	wire half_end = (phase == 8'hff);
	wire last_slot = (slot == slots - 5'h01);
	// last slot absorbs the leftover ticks, hence uneven duty
	wire slot_end = (sub == tpb - 4'h1) && !last_slot;  // [R26]
	wire bit_start = tick && (half_end || slot_end);
	wire [4:0] next_slot = half_end ? 5'h00 : slot + 5'h01;
	// the long last slot lets sub wrap, so only the first match may raise the clock;
	// without the bit_clock gate the receiver would shift several times in that slot
	wire rise_ev = tick && (sub == (tpb >> 1) - 4'h1) && !bit_clock;  // [R26]
	wire next_ws = half_end ? !word_select : word_select;

	// free-running clocks, word select and aux clock
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			phase <= '0;
			sub <= '0;
			slot <= '0;
			word_select <= 1'b0;
			bit_clock <= 1'b0;
			aux_oversample_clock <= 1'b0;
		end
		else if (tick)
		begin
			phase <= phase + 1'b1;
			aux_oversample_clock <= !aux_oversample_clock;  // [R6]
			word_select <= next_ws;  // [R1] [R5]
			if (bit_start)
			begin
				sub <= '0;
				slot <= next_slot;
				bit_clock <= 1'b0;
			end
			else
			begin
				sub <= sub + 1'b1;
				if (rise_ev)
					bit_clock <= 1'b1;  // [R1]
			end
		end
	end

	// transmit fifo
	logic [SB-1:0] tx_head;
	logic [5:0] tx_level;
	wire tx_empty = (tx_level == '0);
	wire tx_full = (tx_level == 6'(FIFO_DEPTH));
	wire [SB-1:0] tx_wdata = w32 ? dat_i[31:8] : dat_i[23:0];  // [R23] [R24]
	wire tx_push = wr_take && sel_port;  // [R15]

	// msb goes out at slot 1, one bit after word select moved
	wire tx_load = bit_start && (next_slot == 5'h01);  // [R4]
	wire tx_mono_right = setup.tx_single_channel && word_select;
	wire tx_pop = tx_load && setup.tx_en && !tx_empty && !tx_mono_right;  // [R9]
	logic [SB-1:0] tx_hold;  // mono sample repeated on right
	logic [SB-1:0] tx_sh;  // transmit shifter
	wire [SB-1:0] tx_pick = tx_mono_right ? tx_hold :
		(tx_empty ? '0 : tx_head);  // [R28]
	wire [SB-1:0] tx_aligned = w16 ? {tx_pick[15:0], 8'h00} :
		w20 ? {tx_pick[19:0], 4'h0} : tx_pick;

	i2sw_fifo #(
		.WIDTH(SB),
		.DEPTH(FIFO_DEPTH),
		.AW(5)
	) u_tx_fifo (  // [R3]
		.sys_clk(sys_clk),
		.clear(tx_clear),
		.push(tx_push),
		.pop(tx_pop),
		.wdata(tx_wdata),
		.rdata(tx_head),
		.level(tx_level)
	);

	// transmit shifter, changes on falling bit clock
	always_ff @(posedge sys_clk)
	begin
		if (tx_clear)
		begin
			tx_sh <= '0;  // [R20]
			tx_hold <= '0;
			serial_out_line <= 1'b0;
		end
		else if (tx_load)
		begin
			serial_out_line <= tx_aligned[SB-1];
			tx_sh <= {tx_aligned[SB-2:0], 1'b0};
			if (!word_select)
				tx_hold <= tx_pick;
		end
		else if (bit_start)
		begin
			serial_out_line <= tx_sh[SB-1];
			tx_sh <= {tx_sh[SB-2:0], 1'b0};
		end
	end

	// serial input passes two flops first
	logic sdi_meta;
	logic sdi_s;
	always_ff @(posedge sys_clk)
	begin
		sdi_meta <= serial_in_line;
		sdi_s <= sdi_meta;
	end

	// receive shifter samples on rising bit clock
	logic [SB-1:0] rx_sh;
	logic [4:0] rx_cnt;  // bits taken in current word
	logic rx_ch;  // channel of current word
	wire rx_first = (slot == 5'h01);
	wire [SB-1:0] rx_next_sh = {rx_sh[SB-2:0], sdi_s};
	wire [4:0] next_rx_cnt = rx_first ? 5'h01 : rx_cnt + 5'h01;
	wire rx_word_ch = rx_first ? word_select : rx_ch;
	wire [SB-1:0] rx_mask = w16 ? 24'h00ffff : w20 ? 24'h0fffff : 24'hffffff;
	wire rx_keep = !setup.rx_single_channel ||
		(rx_word_ch == setup.rx_side_right);  // [R10]
	wire rx_push = rise_ev && setup.rx_en && (next_rx_cnt == nbits) && rx_keep;

	always_ff @(posedge sys_clk)
	begin
		if (rx_clear)
		begin
			rx_sh <= '0;  // [R21]
			rx_cnt <= '0;
			rx_ch <= 1'b0;
		end
		else if (rise_ev)
		begin
			rx_sh <= rx_next_sh;
			rx_ch <= rx_word_ch;
			// saturate so idle slots never match the width
			if (rx_cnt != 5'h1f || rx_first)
				rx_cnt <= next_rx_cnt;
		end
	end

	// receive fifo keeps the channel tag beside each sample
	logic [SB:0] rx_head;
	logic [5:0] rx_level;
	wire rx_empty = (rx_level == '0);
	wire rx_full = (rx_level == 6'(FIFO_DEPTH));
	wire rx_pop = rd_take && sel_port;  // [R15] [R16]

	i2sw_fifo #(
		.WIDTH(SB + 1),
		.DEPTH(FIFO_DEPTH),
		.AW(5)
	) u_rx_fifo (  // [R3]
		.sys_clk(sys_clk),
		.clear(rx_clear),
		.push(rx_push),
		.pop(rx_pop),
		.wdata({rx_word_ch, rx_next_sh & rx_mask}),
		.rdata(rx_head),
		.level(rx_level)
	);

	// read data shaping by width
	wire [SB-1:0] rh = rx_head[SB-1:0];
	wire [31:0] rx_word = w16 ? {{16{rh[15]}}, rh[15:0]} :  // [R25]
		w20 ? {{12{rh[19]}}, rh[19:0]} :
		w32 ? {rh, 8'h00} :  // [R24]
		{{8{rh[23]}}, rh};

	// watermarks and interrupt
	wire tx_wmark = (tx_level < {2'b00, threshold[5:0]}) || (threshold[7:6] != 2'b00);  // [R17]
	wire rx_wmark = (rx_level > {2'b00, threshold[5:0]}) && (threshold[7:6] == 2'b00);  // [R18]

	// status word; rx tag reads right while empty
	i2sw_pkg::i2sw_status_t status;
	assign status.rx_wmark = rx_wmark;  // [R11]
	assign status.rx_full = rx_full;
	assign status.rx_empty = rx_empty;
	assign status.rx_next_right = rx_empty ? 1'b1 : rx_head[SB];  // [R12] [R13]
	assign status.tx_wmark = tx_wmark;
	assign status.tx_full = tx_full;
	assign status.tx_empty = tx_empty;
	assign status.tx_next_right = setup.tx_en && !word_select;  // [R12]

	wire [31:0] rd_mux = sel_div ? {16'h0000, threshold, divider} :
		sel_setup ? {17'h00000, setup} :
		sel_state ? {24'h000000, status} : rx_word;

	// acknowledge and read data, one cycle after take
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ack_o <= 1'b0;
			dat_o <= '0;
			int_o <= 1'b0;
		end
		else
		begin
			ack_o <= take;  // [R22]
			int_o <= (tx_wmark && setup.tx_irq_en) ||
				(rx_wmark && setup.rx_irq_en);  // [R19]
			if (rd_take)
				dat_o <= rd_mux;  // [R14]
		end
	end

endmodule : i2sw_master

// file: bench/i2sw_codec_model.sv
`timescale 1ns/1ps
// far-side converter in loopback: returns each bit within the slot that carries it
module i2sw_codec_model (
	input wire logic bit_clock,
	input wire logic serial_out_line,
	output logic serial_in_line
);
	logic heard = 1'b0; // bit latched on the rising bit clock
	// capture on the rising bit clock, as a converter would
	always @(posedge bit_clock)
		heard <= serial_out_line;
	// follow the line while the clock is low, hold the latched bit while it is high;
	// echoing one slot late would shift every received word by a bit
	assign serial_in_line = bit_clock ? heard : serial_out_line;
endmodule : i2sw_codec_model

// file: bench/i2sw_master_assertions.sv
`timescale 1ns/1ps
// pin-level checks, fed only by the top ports
module i2sw_master_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	input wire logic int_o,
	input wire logic bit_clock,
	input wire logic word_select,
	input wire logic serial_out_line,
	input wire logic serial_in_line,
	input wire logic aux_oversample_clock
);
	logic tx_en_q; // shadow of transmitter enable
	logic irq_en_q; // either interrupt enable set
	logic div0_q; // divider field is zero
	wire take = cyc_i && stb_i && !ack_o; // request taken here
	// shadow the setup and divider fields from bus writes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			tx_en_q <= 1'b0;
			irq_en_q <= 1'b0;
			div0_q <= 1'b1;
		end
		else if (take && we_i && adr_i == i2sw_pkg::ADDR_OPERATING_SETUP)
		begin
			tx_en_q <= dat_i[11];
			irq_en_q <= dat_i[13] || dat_i[14];
		end
		else if (take && we_i && adr_i == i2sw_pkg::ADDR_DIVIDER_AND_THRESHOLD)
			div0_q <= dat_i[7:0] == 8'h00;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sequence take_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	ack_once_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_take_a: assert property (take_s |=> ack_o)
		else $error("no ack one cycle after take");
	ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	dat_hold_a: assert property (!$past(take && !we_i) |-> $stable(dat_o))
		else $error("read data moved without read");
	sdo_idle_a: assert property (!tx_en_q && !$past(tx_en_q, 2) |-> !serial_out_line)
		else $error("serial out active while disabled");
	int_idle_a: assert property (!irq_en_q && !$past(irq_en_q, 2) |-> !int_o)
		else $error("interrupt with enables off");
	ws_edge_a: assert property ($changed(word_select) |-> !bit_clock)
		else $error("word select moved with bit clock high");
	aux_rate_a: assert property (div0_q && $changed(aux_oversample_clock)
		|=> $changed(aux_oversample_clock))
		else $error("aux clock missed a tick");
endmodule : i2sw_master_assertions
bind i2sw_master i2sw_master_assertions i2sw_master_assertions_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
	.ack_o(ack_o), .dat_o(dat_o), .int_o(int_o), .bit_clock(bit_clock),
	.word_select(word_select), .serial_out_line(serial_out_line),
	.serial_in_line(serial_in_line), .aux_oversample_clock(aux_oversample_clock));

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	typedef struct {logic we; logic [1:0] adr; logic [31:0] d; logic [31:0] exp;} i2sw_row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [1:0] adr_i = 2'h0;
	logic [31:0] dat_i = 32'h0;
	logic ack_o, int_o, bit_clock, word_select, serial_out_line, serial_in_line, aux_clk;
	logic [31:0] dat_o;
	logic [31:0] q;
	int error_cnt = 0;
	int checks = 0;
	int n_clk, n_aux, n_bck; // link timing counters
	logic ws_last, aux_last, bck_last; // previous link levels
	// bus rows: reset values, readback, status write ignored
	i2sw_row_t rows[9] = '{'{0, 0, 0, 0}, '{0, 1, 0, 0}, '{0, 2, 0, 32'h32},
		'{1, 0, 32'h500, 0}, '{0, 0, 0, 32'h500}, '{1, 1, 32'h2010, 0},
		'{0, 1, 0, 32'h2010}, '{1, 2, 32'hff, 0}, '{0, 2, 0, 32'h3a}};
	always #4 sys_clk = ~sys_clk;
	i2sw_master i2sw_master_i (.sys_clk(sys_clk), .rst_n(rst_n), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
		.dat_o(dat_o), .int_o(int_o), .bit_clock(bit_clock), .word_select(word_select),
		.serial_out_line(serial_out_line), .serial_in_line(serial_in_line),
		.aux_oversample_clock(aux_clk));
	i2sw_codec_model i2sw_codec_model_i (.bit_clock(bit_clock),
		.serial_out_line(serial_out_line), .serial_in_line(serial_in_line));
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one access; hold until ack is sampled, release at the next falling edge
	task bus(input logic we, input logic [1:0] adr, input logic [31:0] d);
		int n;
		@(negedge sys_clk);
		{cyc_i, stb_i, we_i, adr_i, dat_i} = {2'b11, we, adr, d};
		n = 0;
		do
		begin
			@(negedge sys_clk);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		if (n >= 20)
			error_cnt++;
		@(negedge sys_clk);
		{cyc_i, stb_i} = 2'b00;
	endtask : bus
	task conclude;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	// watchdog well past the expected run
	initial
	begin
		#60000;
		error_cnt++;
		conclude();
	end
	initial
	begin
		repeat (3) @(negedge sys_clk);
		rst_n = 1'b1;
		foreach (rows[i])
		begin
			bus(rows[i].we, rows[i].adr, rows[i].d);
			if (!rows[i].we)
				check(q, rows[i].exp, "register");
		end
		check(int_o, 1'b1, "int_o");
		// flood the tx fifo well past its depth with a negative 16-bit sample
		bus(1, 1, 32'h810);
		repeat (36) bus(1, 3, 32'h00ff8a5c);
		bus(0, 2, 0);
		check(q & 32'h6, 32'h4, "tx full");
		check(int_o, 1'b0, "int_o off");
		// loop back through the codec, second word is whole
		bus(1, 1, 32'h1810);
		repeat (1600) @(negedge sys_clk);
		bus(0, 3, 0);
		bus(0, 3, 0);
		check(q, 32'hffff8a5c, "rx word");
		// link timing over one word select half, prescaler dividing by two
		bus(1, 0, 32'h501);
		n_clk = 0;
		ws_last = word_select;
		while (word_select === ws_last && n_clk < 1200)
		begin
			@(negedge sys_clk);
			n_clk++;
		end
		n_clk = 0;
		n_aux = 0;
		n_bck = 0;
		ws_last = word_select;
		aux_last = aux_clk;
		bck_last = bit_clock;
		do
		begin
			@(negedge sys_clk);
			n_clk++;
			n_aux += (aux_clk !== aux_last);
			n_bck += (bit_clock === 1'b1 && bck_last === 1'b0);
			aux_last = aux_clk;
			bck_last = bit_clock;
		end
		while (word_select === ws_last && n_clk < 1200);
		check(n_clk, 32'h200, "half frame clocks");
		check(n_aux, 32'h100, "aux edges per half");
		check(n_bck, 32'h10, "bit clocks per half");
		// disabling both sections clears them
		bus(1, 1, 32'h10);
		repeat (4) bus(0, 3, 0);
		bus(0, 2, 0);
		check(q, 32'h3a, "status cleared");
		check(serial_out_line, 1'b0, "serial out");
		// mid-run reset brings every register back
		@(negedge sys_clk);
		rst_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		rst_n = 1'b1;
		bus(0, 0, 0);
		check(q, 32'h0, "control after reset");
		bus(0, 1, 0);
		check(q, 32'h0, "setup after reset");
		bus(0, 2, 0);
		check(q, 32'h32, "status after reset");
		check(int_o, 1'b0, "int_o after reset");
		conclude();
	end
endmodule : testbench
